// [rtl/csd_pkg.sv]
`default_nettype none
package csd_pkg;

    // ==========================================================
    // Register map on the APB port.
    localparam logic [7:0] CSD_CTRL_OFS   = 8'h00;
    localparam logic [7:0] CSD_STATUS_OFS = 8'h04;
    localparam logic [7:0] CSD_MASK_OFS   = 8'h08;
    localparam logic [7:0] CSD_CAUSE_OFS  = 8'h0C;
    localparam int         CSD_EN_BIT     = 0;
    localparam logic       CSD_EN_RST     = 1'b1;
    localparam int         CSD_ST_W       = 4;
    localparam logic [3:0] CSD_MASK_RST   = 4'h0;
    localparam int         CSD_ST_STORE   = 0;
    localparam int         CSD_ST_ALIGN   = 1;
    localparam int         CSD_ST_DEBUG   = 2;
    localparam int         CSD_ST_MEM     = 3;

    // ==========================================================
    // Major opcodes and minor fields of the compact group.
    localparam logic [5:0] CSD_OP_POOL_A  = 6'h01;
    localparam logic [5:0] CSD_OP_POOL_B  = 6'h09;
    localparam logic [5:0] CSD_OP_GROUP_C = 6'h11;
    localparam logic [5:0] CSD_OP_POOL_F  = 6'h21;
    localparam logic [5:0] CSD_OP_BYTE_ST = 6'h22;
    localparam logic [5:0] CSD_OP_HALF_ST = 6'h2A;
    localparam logic [5:0] CSD_OP_WORD_ST = 6'h3A;
    localparam logic [3:0] CSD_FN_INVERT  = 4'h0;
    localparam logic [3:0] CSD_FN_OR      = 4'h3;
    localparam logic [5:0] CSD_FN_BREAK   = 6'h2C;

    // ==========================================================
    // Exception and debug cause codes reported by the block, and the shift count of code 0.
    localparam logic [1:0] CSD_EXC_NONE   = 2'h0;
    localparam logic [1:0] CSD_EXC_ADDR   = 2'h1;
    localparam logic [1:0] CSD_EXC_DBG    = 2'h2;
    localparam logic [1:0] CSD_EXC_DBG_DM = 2'h3;
    localparam logic [4:0] CSD_DBG_CAUSE_BP  = 5'h09;
    localparam logic [4:0] CSD_DBG_CAUSE_RST = 5'h00;
    localparam logic [3:0] CSD_SHIFT_CODE0   = 4'h8;

endpackage
`default_nettype wire

// [rtl/csd_top.sv]
// How it works
// - Pair move sources decode 0,17,2,3,16,18,19,20 from the 3-bit code.
// - Pair move destination code picks one of eight fixed register pairs.
// - Pair move in a delay slot is undefined; software must avoid it.
// - Invert writes source XOR all-ones to target, no exception.
// - Logic, shift, subtract register fields reach only registers 2-7, 16, 17.
// - OR writes source OR target back to target, no exception.
// - Byte store writes low byte at base plus 4-bit unsigned offset, unaligned.
// - Store base field selects 2-7,16,17; data field selects 0,2-7,17.
// - Byte store may raise memory path exceptions like TLB, bus, watch.
// - Breakpoint raises debug exception, or in debug mode sets cause 0x9.
// - Hardware ignores the breakpoint's 4-bit code field.
// - Halfword store writes low 16 bits at base plus offset times two.
// - Halfword store with odd address raises address error, no store.
// - Left shift fills zeros; code 0 means eight, others themselves.
// - Right shift fills zeros; same shift code decoding.
// - Subtract writes first minus second modulo 2^32, never overflows.
// - Word store writes the word at base plus offset times four.
// - Word store with low address bits nonzero raises address error, no store.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module csd_top (
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic        i_in_debug_mode_flag,
    input  wire logic        i_gpr_wr_en,
    input  wire logic [4:0]  i_gpr_wr_addr,
    input  wire logic [31:0] i_gpr_wr_data,
    input  wire logic [4:0]  i_gpr_rd_addr,
    output logic      [31:0] o_gpr_rd_data,
    output logic             o_store_valid,
    output logic      [31:0] o_store_addr,
    output logic      [31:0] o_store_data,
    output logic      [3:0]  o_store_be,
    input  wire logic        i_mem_exc_valid,
    input  wire logic [2:0]  i_mem_exc_code,
    output logic             o_mem_exc_valid,
    output logic      [2:0]  o_mem_exc_code,
    output logic             o_exc_valid,
    output logic      [1:0]  o_exc_code,
    output logic      [4:0]  o_debug_exception_cause,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq
);

    // ==========================================================
    // Register codes.
    function automatic logic [4:0] f_gpr8(input logic [2:0] c);
        f_gpr8 = (c == 3'h6) ? 5'd16 : (c == 3'h7) ? 5'd17 : {2'b00, c} + 5'd2;
    endfunction
    // Pair move tables indexed by the 3-bit code; entry 0 sits in the lowest bits.
    function automatic logic [4:0] f_pair_src(input logic [2:0] c);
        logic [7:0][4:0] tbl;
        tbl        = {5'd20, 5'd19, 5'd18, 5'd16, 5'd3, 5'd2, 5'd17, 5'd0};
        f_pair_src = tbl[c];
    endfunction
    function automatic logic [9:0] f_pair_dst(input logic [2:0] c);
        logic [7:0][9:0] tbl;
        tbl = {5'd4, 5'd7, 5'd4, 5'd6, 5'd4, 5'd5, 5'd4, 5'd22, 5'd4, 5'd21, 5'd6, 5'd7, 5'd5, 5'd7, 5'd5, 5'd6};
        f_pair_dst = tbl[c];
    endfunction
    // Data field of a store: 0 reads zero, 1 reads 17, others themselves.
    function automatic logic [4:0] f_st_data(input logic [2:0] c);
        f_st_data = (c == 3'h1) ? 5'd17 : {2'b00, c};
    endfunction

    // ==========================================================
    // State.
    logic [31:0]         gpr_q [32];
    logic                en_q;
    logic [3:0]          mask_q;
    logic [3:0]          status_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic                irq_q;
    // ==========================================================
    // Decode.
    logic [5:0]  op;
    logic        go;
    logic        is_sub, is_sll, is_srl, is_not, is_or, is_bp;
    logic        is_pair, is_sb, is_sh, is_sw, is_st;
    logic [4:0]  a_idx, b_idx, wr1_addr, wr2_addr, shamt;
    logic [31:0] a_val, b_val, wr1_data, wr2_data, ea;
    logic        wr1_en, wr2_en, misalign;
    logic [31:0] st_data;
    logic [3:0]  st_be;
    assign op      = i_instr[15:10];
    assign go      = i_instr_valid & en_q;
    assign is_sub  = go & (op == csd_pkg::CSD_OP_POOL_A) & i_instr[0];
    assign is_sll  = go & (op == csd_pkg::CSD_OP_POOL_B) & ~i_instr[0];
    assign is_srl  = go & (op == csd_pkg::CSD_OP_POOL_B) & i_instr[0];
    assign is_not  = go & (op == csd_pkg::CSD_OP_GROUP_C) & (i_instr[9:6] == csd_pkg::CSD_FN_INVERT);
    assign is_or   = go & (op == csd_pkg::CSD_OP_GROUP_C) & (i_instr[9:6] == csd_pkg::CSD_FN_OR);
    assign is_bp   = go & (op == csd_pkg::CSD_OP_GROUP_C) & (i_instr[9:4] == csd_pkg::CSD_FN_BREAK);
    assign is_pair = go & (op == csd_pkg::CSD_OP_POOL_F) & ~i_instr[0];
    assign is_sb   = go & (op == csd_pkg::CSD_OP_BYTE_ST);
    assign is_sh   = go & (op == csd_pkg::CSD_OP_HALF_ST);
    assign is_sw   = go & (op == csd_pkg::CSD_OP_WORD_ST);
    assign is_st   = is_sb | is_sh | is_sw;
    assign a_val   = gpr_q[a_idx];
    assign b_val   = gpr_q[b_idx];
    // Code 0 of the shift field stands for eight.
    assign shamt = (i_instr[3:1] == 3'h0) ? {1'b0, csd_pkg::CSD_SHIFT_CODE0} : {2'b00, i_instr[3:1]};

    // Operand selection and results; the pair move runs even in a delay slot.
    always_comb
    begin
        a_idx    = 5'd0;
        b_idx    = 5'd0;
        wr1_en   = 1'b0;
        wr2_en   = 1'b0;
        wr1_addr = 5'd0;
        wr2_addr = 5'd0;
        wr1_data = 32'h0000_0000;
        wr2_data = 32'h0000_0000;
        if (is_sub)
        begin
            a_idx    = f_gpr8(i_instr[3:1]);
            b_idx    = f_gpr8(i_instr[6:4]);
            wr1_en   = 1'b1;
            wr1_addr = f_gpr8(i_instr[9:7]);
            wr1_data = a_val - b_val;
        end
        else if (is_sll | is_srl)
        begin
            a_idx    = f_gpr8(i_instr[6:4]);
            wr1_en   = 1'b1;
            wr1_addr = f_gpr8(i_instr[9:7]);
            wr1_data = is_srl ? (a_val >> shamt) : (a_val << shamt);
        end
        else if (is_not | is_or)
        begin
            a_idx    = f_gpr8(i_instr[2:0]);
            b_idx    = f_gpr8(i_instr[5:3]);
            wr1_en   = 1'b1;
            wr1_addr = b_idx;
            wr1_data = is_not ? (a_val ^ 32'hFFFF_FFFF) : (a_val | b_val);
        end
        else if (is_pair)
        begin
            a_idx    = f_pair_src(i_instr[3:1]);
            b_idx    = f_pair_src(i_instr[6:4]);
            wr1_en   = 1'b1;
            wr2_en   = 1'b1;
            {wr1_addr, wr2_addr} = f_pair_dst(i_instr[9:7]);
            wr1_data = a_val;
            wr2_data = b_val;
        end
        else if (is_st)
        begin
            a_idx = f_gpr8(i_instr[6:4]);
            b_idx = f_st_data(i_instr[9:7]);
        end
    end

    // Effective address and lane placement of store data, little-endian lanes.
    always_comb
    begin
        ea       = a_val + {28'h000_0000, i_instr[3:0]};
        st_be    = 4'h1 << ea[1:0];
        st_data  = {4{b_val[7:0]}};
        misalign = 1'b0;
        if (is_sh)
        begin
            ea       = a_val + {27'h000_0000, i_instr[3:0], 1'b0};
            st_be    = ea[1] ? 4'hC : 4'h3;
            st_data  = {2{b_val[15:0]}};
            misalign = ea[0];
        end
        else if (is_sw)
        begin
            ea       = a_val + {26'h000_0000, i_instr[3:0], 2'b00};
            st_be    = 4'hF;
            st_data  = b_val;
            misalign = |ea[1:0];
        end
    end

    // ==========================================================
    // Register file; register zero is never written.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            gpr_q <= '{default: 32'h0000_0000};
        end
        else
        begin
            if (i_gpr_wr_en && i_gpr_wr_addr != 5'd0)
            begin
                gpr_q[i_gpr_wr_addr] <= i_gpr_wr_data;
            end
            if (wr1_en)
            begin
                gpr_q[wr1_addr] <= wr1_data;
            end
            if (wr2_en)
            begin
                gpr_q[wr2_addr] <= wr2_data;
            end
        end
    end

    // Registered read port for the pipeline.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_gpr_rd_data <= 32'h0000_0000;
        end
        else
        begin
            o_gpr_rd_data <= gpr_q[i_gpr_rd_addr];
        end
    end

    // ==========================================================
    // Store requests and exceptions; a misaligned store never issues.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_store_valid <= 1'b0;
            o_store_addr  <= 32'h0000_0000;
            o_store_data  <= 32'h0000_0000;
            o_store_be    <= 4'h0;
            o_exc_valid   <= 1'b0;
            o_exc_code    <= csd_pkg::CSD_EXC_NONE;
        end
        else
        begin
            o_store_valid <= is_st & ~misalign;
            o_store_addr  <= ea;
            o_store_data  <= st_data;
            o_store_be    <= st_be;
            o_exc_valid   <= (is_st & misalign) | is_bp;
            if (is_st & misalign)
            begin
                o_exc_code <= csd_pkg::CSD_EXC_ADDR;
            end
            else if (is_bp)
            begin
                o_exc_code <= i_in_debug_mode_flag ? csd_pkg::CSD_EXC_DBG_DM : csd_pkg::CSD_EXC_DBG;
            end
            else
            begin
                o_exc_code <= csd_pkg::CSD_EXC_NONE;
            end
        end
    end

    // Debug cause is loaded only by a breakpoint taken in debug mode.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_debug_exception_cause <= csd_pkg::CSD_DBG_CAUSE_RST;
        end
        else if (is_bp && i_in_debug_mode_flag)
        begin
            o_debug_exception_cause <= csd_pkg::CSD_DBG_CAUSE_BP;
        end
    end

    // Faults found by translation of a store are passed on one cycle later.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_mem_exc_valid <= 1'b0;
            o_mem_exc_code  <= 3'h0;
        end
        else
        begin
            o_mem_exc_valid <= i_mem_exc_valid;
            o_mem_exc_code  <= i_mem_exc_code;
        end
    end

    // ==========================================================
    // APB slave: zero wait states, pready high in the access phase.
    logic       setup, acc, unmapped;
    logic [3:0] ev_set, rd_clr;
    assign setup    = i_psel & ~i_penable;
    assign acc      = i_psel & i_penable & pready_q;
    assign unmapped = (i_paddr != csd_pkg::CSD_CTRL_OFS) && (i_paddr != csd_pkg::CSD_STATUS_OFS)
                   && (i_paddr != csd_pkg::CSD_MASK_OFS) && (i_paddr != csd_pkg::CSD_CAUSE_OFS);
    // Read data is latched at the setup edge, so it stands through the access cycle.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup & unmapped;
            if (setup && !i_pwrite)
            begin
                unique case (i_paddr)
                    csd_pkg::CSD_CTRL_OFS:   prdata_q <= {31'h0, en_q};
                    csd_pkg::CSD_STATUS_OFS: prdata_q <= {28'h0, status_q};
                    csd_pkg::CSD_MASK_OFS:   prdata_q <= {28'h0, mask_q};
                    csd_pkg::CSD_CAUSE_OFS:  prdata_q <= {25'h0, o_debug_exception_cause, o_exc_code};
                    default:                 prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control and mask writes take effect at the access edge.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            en_q   <= csd_pkg::CSD_EN_RST;
            mask_q <= csd_pkg::CSD_MASK_RST;
        end
        else if (acc && i_pwrite && i_paddr == csd_pkg::CSD_CTRL_OFS)
        begin
            en_q <= i_pwdata[csd_pkg::CSD_EN_BIT];
        end
        else if (acc && i_pwrite && i_paddr == csd_pkg::CSD_MASK_OFS)
        begin
            mask_q <= i_pwdata[3:0];
        end
    end

    // Sticky events; a read clears only the bits it returned, a new event wins.
    always_comb
    begin
        ev_set = '0;
        ev_set[csd_pkg::CSD_ST_STORE] = o_store_valid;
        ev_set[csd_pkg::CSD_ST_ALIGN] = o_exc_valid & (o_exc_code == csd_pkg::CSD_EXC_ADDR);
        ev_set[csd_pkg::CSD_ST_DEBUG] = o_exc_valid & (o_exc_code != csd_pkg::CSD_EXC_ADDR);
        ev_set[csd_pkg::CSD_ST_MEM]   = o_mem_exc_valid;
        rd_clr = (acc && !i_pwrite && i_paddr == csd_pkg::CSD_STATUS_OFS) ? prdata_q[3:0] : 4'h0;
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            status_q <= 4'h0;
            irq_q    <= 1'b0;
        end
        else
        begin
            status_q <= (status_q & ~rd_clr) | ev_set;
            irq_q    <= |(((status_q & ~rd_clr) | ev_set) & mask_q);
        end
    end

    assign o_prdata  = prdata_q;
    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_irq     = irq_q;

    // ==========================================================
    // Checks.
    pair_src_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_pair |-> a_idx inside {5'd0, 5'd2, 5'd3, [5'd16:5'd20]}) else $error("Bad pair move source.");
    pair_dst_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_pair |=> gpr_q[$past(wr2_addr)] == $past(b_val)) else $error("Pair move second write wrong.");
    alu_regs_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        (is_sub | is_or) |-> b_idx inside {[5'd2:5'd7], 5'd16, 5'd17}) else $error("Bad register code.");
    invert_res_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_not |=> gpr_q[$past(wr1_addr)] == ~$past(a_val) && !o_exc_valid) else $error("Invert wrong.");
    sub_res_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_sub |=> !o_exc_valid && gpr_q[$past(wr1_addr)] == $past(a_val) - $past(b_val)) else $error("Subtract wrong.");
    shift_eight_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_sll && i_instr[3:1] == 3'h0 |=> gpr_q[$past(wr1_addr)] == {$past(a_val[23:0]), 8'h00}) else $error("Shift wrong.");
    byte_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_sb |=> o_store_valid && o_store_addr == $past(a_val) + {28'h0, $past(i_instr[3:0])}) else $error("Byte store wrong.");
    half_align_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_sh && ea[0] |=> o_exc_valid && o_exc_code == csd_pkg::CSD_EXC_ADDR && !o_store_valid) else $error("Half align.");
    word_align_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_sw && ea[1:0] != 2'b00 |=> o_exc_valid && !o_store_valid) else $error("Word align missed.");
    debug_cause_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        is_bp && i_in_debug_mode_flag |=> o_debug_exception_cause == 5'h09 && o_exc_code == 2'h3) else $error("Debug cause.");

endmodule

`default_nettype wire

// [verif/csd_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Memory side: takes store requests and can answer one with a fault.
module csd_mem_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_store_valid,
    input  wire logic       i_fault_en,
    output logic            o_exc_valid,
    output logic      [2:0] o_exc_code
);
    // A fault follows its store by one edge; the code toggles when idle.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_exc_valid <= 1'b0;
            o_exc_code  <= 3'h0;
        end
        else
        begin
            o_exc_valid <= i_store_valid & i_fault_en;
            o_exc_code  <= (i_store_valid & i_fault_en) ? 3'h5 : ~o_exc_code;
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        iv = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic        dm = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  wa = 5'h00;
    logic [4:0]  ra = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, sa, sdat, prd, v;
    logic [3:0]  sbe;
    logic [2:0]  mec, omec, k;
    logic [1:0]  ec;
    logic [4:0]  dc;
    logic        sv, mev, omev, ev, ready, err, irq, pe;
    logic        flt = 1'b0;
    logic        en = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] gm [32] = '{default: 32'h0};
    logic [4:0]  st [8] = '{5'h00, 5'h11, 5'h02, 5'h03, 5'h10, 5'h12, 5'h13, 5'h14};
    logic [4:0]  d1 [8] = '{5'h05, 5'h05, 5'h06, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
    logic [4:0]  d2 [8] = '{5'h06, 5'h07, 5'h07, 5'h15, 5'h16, 5'h05, 5'h06, 5'h07};
    int          bad_count = 0;
    int          checked = 0;

    csd_top csd_top_i (.i_ref_clk(clk), .i_arst_n(rst_n), .i_instr_valid(iv), .i_instr(ins),
        .i_in_debug_mode_flag(dm), .i_gpr_wr_en(we), .i_gpr_wr_addr(wa), .i_gpr_wr_data(wd),
        .i_gpr_rd_addr(ra), .o_gpr_rd_data(rdat), .o_store_valid(sv), .o_store_addr(sa),
        .o_store_data(sdat), .o_store_be(sbe), .i_mem_exc_valid(mev), .i_mem_exc_code(mec),
        .o_mem_exc_valid(omev), .o_mem_exc_code(omec), .o_exc_valid(ev), .o_exc_code(ec),
        .o_debug_exception_cause(dc), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(ready), .o_pslverr(err), .o_irq(irq));
    csd_mem_model csd_mem_model_i (.i_ref_clk(clk), .i_arst_n(rst_n), .i_store_valid(sv),
        .i_fault_en(flt), .o_exc_valid(mev), .o_exc_code(mec));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // ====
    // Helpers.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h saw %h", n, e, s);
        end
    endtask

    function automatic logic [4:0] r3(input logic [2:0] c);
        return (c < 3'h6) ? 5'(c) + 5'h02 : 5'(c) + 5'h0A;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ready !== 1'b1 && n < 20);
        q = prd;
        pe = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (ready !== 1'b1)
        begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic load(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        if (a != 5'h00)
            gm[a] = d;
    endtask

    // Issues one instruction, predicts its effects, then compares the store, exception and memory fault outputs and every register.
    task automatic run(input logic [15:0] i);
        logic [31:0] a, b, ea, ed, m;
        logic [3:0]  be, sh;
        logic [1:0]  x;
        logic        s;
        s = 1'b0;
        x = csd_pkg::CSD_EXC_NONE;
        be = 4'h0;
        ea = 32'h0;
        ed = 32'h0;
        a = gm[r3(i[6:4])];
        b = gm[(i[9:7] == 3'h1) ? 5'h11 : 5'(i[9:7])];
        sh = (i[3:1] == 3'h0) ? 4'h8 : 4'(i[3:1]);
        if (en)
            case (i[15:10])
                csd_pkg::CSD_OP_POOL_F:
                begin
                    m = gm[st[i[3:1]]];
                    gm[d2[i[9:7]]] = gm[st[i[6:4]]];
                    gm[d1[i[9:7]]] = m;
                end
                csd_pkg::CSD_OP_GROUP_C:
                    if (i[9:4] == csd_pkg::CSD_FN_BREAK)
                        x = dm ? csd_pkg::CSD_EXC_DBG_DM : csd_pkg::CSD_EXC_DBG;
                    else if (i[9:6] == csd_pkg::CSD_FN_INVERT)
                        gm[r3(i[5:3])] = gm[r3(i[2:0])] ^ 32'hFFFF_FFFF;
                    else if (i[9:6] == csd_pkg::CSD_FN_OR)
                        gm[r3(i[5:3])] = gm[r3(i[2:0])] | gm[r3(i[5:3])];
                csd_pkg::CSD_OP_POOL_B:
                    gm[r3(i[9:7])] = i[0] ? a >> sh : a << sh;
                csd_pkg::CSD_OP_POOL_A:
                    gm[r3(i[9:7])] = gm[r3(i[3:1])] - a;
                csd_pkg::CSD_OP_BYTE_ST:
                begin
                    ea = a + 32'(i[3:0]);
                    s = 1'b1;
                    ed = {4{b[7:0]}};
                    be = 4'h1 << ea[1:0];
                end
                csd_pkg::CSD_OP_HALF_ST:
                begin
                    ea = a + 32'({i[3:0], 1'b0});
                    s = !ea[0];
                    ed = {2{b[15:0]}};
                    be = 4'h3 << ea[1:0];
                end
                csd_pkg::CSD_OP_WORD_ST:
                begin
                    ea = a + 32'({i[3:0], 2'h0});
                    s = (ea[1:0] == 2'h0);
                    ed = b;
                    be = 4'hF;
                end
                default: ;
            endcase
        if (!s && (i[15:10] == csd_pkg::CSD_OP_HALF_ST || i[15:10] == csd_pkg::CSD_OP_WORD_ST))
            x = csd_pkg::CSD_EXC_ADDR;
        // Pair moves are only ever issued as ordinary instructions.
        @(posedge clk);
        ins <= i;
        iv <= 1'b1;
        @(posedge clk);
        iv <= 1'b0;
        #1;
        chk("store_valid", sv, s);
        if (s)
        begin
            chk("store_addr", sa, ea);
            chk("store_data", sdat, ed);
            chk("store_be", sbe, be);
        end
        chk("exc", {ev, ec}, {x != 2'h0, x});
        repeat (2) @(posedge clk);
        #1;
        chk("mem_exc", omev, s & flt);
        if (s & flt)
            chk("mem_code", omec, 3'h5);
        for (int r = 0; r < 32; r++)
        begin
            @(posedge clk);
            ra <= 5'(r);
            @(posedge clk);
            #1;
            chk("gpr", rdat, gm[r]);
        end
    endtask

    // ====
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b0, 8'(c * 4), 32'h0, v);
            chk("reset_reg", v, 32'(c == 0));
        end
        apb(1'b0, 8'h10, 32'h0, v);
        chk("slverr", pe, 1'b1);
        for (int r = 0; r < 32; r++)
            load(5'(r), 32'(32'h9E37_79B9 * r));
        for (int c = 0; c < 8; c++)
        begin
            k = 3'(c);
            run({csd_pkg::CSD_OP_POOL_F, k, k, ~k, 1'b0});
            run({csd_pkg::CSD_OP_GROUP_C, csd_pkg::CSD_FN_INVERT, k, ~k});
            run({csd_pkg::CSD_OP_GROUP_C, csd_pkg::CSD_FN_OR, k, k + 3'h3});
            run({csd_pkg::CSD_OP_POOL_B, k, ~k, k, 1'b0});
            run({csd_pkg::CSD_OP_POOL_B, k, k + 3'h1, k, 1'b1});
            run({csd_pkg::CSD_OP_POOL_A, k, k + 3'h2, k + 3'h5, 1'b1});
        end
        load(5'h02, 32'h0000_1000);
        load(5'h10, 32'h0000_2001);
        for (int c = 0; c < 8; c++)
        begin
            k = 3'(c);
            run({csd_pkg::CSD_OP_BYTE_ST, k, 3'h6, k, 1'b1});
            run({csd_pkg::CSD_OP_HALF_ST, k, 3'h0, k, 1'b0});
            run({csd_pkg::CSD_OP_HALF_ST, k, 3'h6, 4'h3});
            run({csd_pkg::CSD_OP_WORD_ST, k, 3'h0, 1'b0, k});
            run({csd_pkg::CSD_OP_WORD_ST, k, 3'h6, k, 1'b0});
        end
        flt <= 1'b1;
        run({csd_pkg::CSD_OP_WORD_ST, 3'h3, 3'h0, 4'h2});
        flt <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clk);
            dm <= c[1];
            @(posedge clk);
            run({csd_pkg::CSD_OP_GROUP_C, csd_pkg::CSD_FN_BREAK, c[0] ? 4'hF : 4'h0});
            chk("dbg_cause", dc, c[1] ? 32'h9 : 32'h0);
        end
        apb(1'b0, csd_pkg::CSD_CAUSE_OFS, 32'h0, v);
        chk("cause_reg", v, 32'h24);
        // A disabled decoder must leave every register untouched.
        apb(1'b1, csd_pkg::CSD_CTRL_OFS, 32'h0, v);
        en = 1'b0;
        run({csd_pkg::CSD_OP_GROUP_C, csd_pkg::CSD_FN_INVERT, 3'h1, 3'h2});
        apb(1'b1, csd_pkg::CSD_CTRL_OFS, 32'h1, v);
        en = 1'b1;
        // Sticky status, mask and interrupt level.
        apb(1'b0, csd_pkg::CSD_STATUS_OFS, 32'h0, v);
        chk("status_all", v, 32'hF);
        run({csd_pkg::CSD_OP_BYTE_ST, 3'h2, 3'h0, 4'h1});
        chk("irq_masked", irq, 1'b0);
        apb(1'b1, csd_pkg::CSD_MASK_OFS, 32'h1, v);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_on", irq, 1'b1);
        apb(1'b0, csd_pkg::CSD_STATUS_OFS, 32'h0, v);
        chk("status_store", v, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_off", irq, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
